// ===== hdl/lwc_ram_ctrl.sv
// synchronous controller driving a lut ram primitive through its pins
`include "lwc_regs.svh"
`default_nettype none
module lwc_ram_ctrl
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // user command port
  input  wire logic                      cmdValid,
  input  wire logic                      cmdWrite,
  input  wire logic [`LWC_ADDR_BITS-1:0] cmdAddr,
  input  wire logic                      cmdData,
  output var  logic                      cmdReady,
  // user answer port
  output var  logic                      rspValid,
  output var  logic                      rspData,
  // ram primitive pins
  output var  logic [`LWC_ADDR_BITS-1:0] ramAddr,
  output var  logic                      ramDataIn,
  output var  logic                      ramWriteEn,
  input  wire logic                      ramDataOut
);

  // sequencer link
  lwc_seq_if seqIf ();

  lwc_johnson_seq uSeq
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .seqIf   (seqIf)
  );

  // strobe decode: two adjacent johnson bits, so only one input moves while the sequencer runs
  function automatic logic strobeDecode(input lwc_pkg::lwc_phase_type ph);
    strobeDecode = ph[`LWC_STB_HI] & ph[`LWC_STB_LO];
  endfunction

  // phase compare used by both access kinds
  function automatic logic atPhase(input lwc_pkg::lwc_phase_type ph,
                                   input lwc_pkg::lwc_phase_type want);
    atPhase = (ph == want);
  endfunction

  lwc_pkg::lwc_state_type        state_r;      // controller state
  lwc_pkg::lwc_state_type        state_nxt;
  logic [`LWC_ADDR_BITS-1:0]     addr_r;       // address held on the ram pins
  logic [`LWC_ADDR_BITS-1:0]     addr_nxt;
  logic                          wdata_r;      // data held on the ram input
  logic                          wdata_nxt;
  logic                          strobe_r;     // write strobe, active high
  logic                          strobe_nxt;
  logic                          ready_r;      // command port ready
  logic                          ready_nxt;
  logic                          rspValid_r;   // one-cycle answer pulse
  logic                          rspValid_nxt;
  logic                          rspData_r;    // sampled ram output
  logic                          rspData_nxt;

  // end of an access: a read ends once the output has settled for two
  // phases, a write once the strobe has fallen and a hold phase has passed
  function automatic logic accessDone(input lwc_pkg::lwc_state_type st,
                                      input lwc_pkg::lwc_phase_type ph);
    case (st)
      lwc_pkg::LWC_READ:
      begin
        accessDone = atPhase(ph, `LWC_JS_SAMPLE);
      end
      lwc_pkg::LWC_WRITE:
      begin
        accessDone = atPhase(ph, `LWC_JS_LAST);
      end
      default:
      begin
        accessDone = `LWC_BIT_RST; // idle has nothing to finish
      end
    endcase
  endfunction

  // decodes shared by the three groups below
  logic                          takeCmd;      // command accepted at this edge
  logic                          answerDue;    // last cycle of the access

  // sequencer runs only while an access is under way
  assign seqIf.run = (state_r != lwc_pkg::LWC_IDLE);

  // a command is taken only while idle and ready; one offered while busy is
  // simply dropped, so the user keeps cmdValid up until it sees cmdReady
  assign takeCmd = cmdValid && ready_r && (state_r == lwc_pkg::LWC_IDLE);

  // the answer falls on a fixed johnson phase for each access kind
  assign answerDue = accessDone(state_r, seqIf.phase);

  // control group: state and ready
  always_comb
  begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    case (state_r)
      lwc_pkg::LWC_IDLE:
      begin
        // the access kind is fixed at the take edge and held to the end
        if (takeCmd)
        begin
          ready_nxt = `LWC_BIT_RST;
          if (cmdWrite)
          begin
            state_nxt = lwc_pkg::LWC_WRITE;
          end
          else
          begin
            state_nxt = lwc_pkg::LWC_READ;
          end
        end
      end
      lwc_pkg::LWC_READ,
      lwc_pkg::LWC_WRITE:
      begin
        // ready returns with the answer, so the next command can be taken
        // in the very cycle that the answer stands
        if (answerDue)
        begin
          ready_nxt = `LWC_READY_RST;
          state_nxt = lwc_pkg::LWC_IDLE;
        end
      end
      default:
      begin
        // an unused code falls back to idle rather than locking up
        state_nxt = lwc_pkg::LWC_IDLE;
        ready_nxt = `LWC_READY_RST;
      end
    endcase
  end

  // control group registers, synchronous reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= lwc_pkg::LWC_IDLE;
      ready_r <= `LWC_READY_RST;
    end
    else
    begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ram pin group: address, data and strobe
  always_comb
  begin
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    strobe_nxt = `LWC_BIT_RST; // strobe low in idle and reads
    // address and data move only at the take edge, with the strobe low
    if (takeCmd)
    begin
      addr_nxt = cmdAddr;
      if (cmdWrite)
      begin
        wdata_nxt = cmdData;
      end
    end
    // strobe is a flop fed by a hazard-free decode, never a gated
    // counter, so even a tiny glitch cannot reach the ram
    if (state_r == lwc_pkg::LWC_WRITE)
    begin
      strobe_nxt = strobeDecode(seqIf.phase);
    end
  end

  // ram pin group registers; the address stays put until the next take,
  // which covers the hold after the strobe falls with a whole cycle to spare
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addr_r   <= `LWC_ADDR_RST;
      wdata_r  <= `LWC_BIT_RST;
      strobe_r <= `LWC_BIT_RST;
    end
    else
    begin
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  // answer group: one-cycle valid pulse and the held sample
  always_comb
  begin
    rspValid_nxt = `LWC_BIT_RST;
    rspData_nxt  = rspData_r;
    // a read samples the settled output, a write reads back the new word
    if (answerDue)
    begin
      rspData_nxt  = ramDataOut;
      rspValid_nxt = `LWC_BIT_SET;
    end
  end

  // answer group registers, synchronous reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rspValid_r <= `LWC_BIT_RST;
      rspData_r  <= `LWC_BIT_RST;
    end
    else
    begin
      rspValid_r <= rspValid_nxt;
      rspData_r  <= rspData_nxt;
    end
  end

  // every output straight from a flop; ram output is a plain input since
  // the primitive always drives it
  assign cmdReady   = ready_r;
  assign rspValid   = rspValid_r;
  assign rspData    = rspData_r;
  assign ramAddr    = addr_r;  // for the 16-word form keep addr msb low
  assign ramDataIn  = wdata_r;
  assign ramWriteEn = strobe_r;

endmodule
`default_nettype wire

// ===== hdl/lwc_regs.svh
// named constants for the lut ram write controller
`ifndef LWC_REGS_SVH
`define LWC_REGS_SVH

// address width of the 32-word form; the 16-word form ties the top bit low
`define LWC_ADDR_BITS      5
// word count of the larger and the smaller primitive
`define LWC_DEPTH_LARGE    32
`define LWC_DEPTH_SMALL    16

// clock period and the address hold after the strobe falls, in ns
`define LWC_CLK_NS         20
`define LWC_HOLD_NS        2
// hold in cycles, rounded up, at least one
`define LWC_HOLD_CYC       (((`LWC_HOLD_NS + `LWC_CLK_NS - 1) / `LWC_CLK_NS) < 1 ? 1 : \
                            ((`LWC_HOLD_NS + `LWC_CLK_NS - 1) / `LWC_CLK_NS))

// johnson phases of the three-bit sequencer
`define LWC_JS_REST        3'h0
`define LWC_JS_P1          3'h1
`define LWC_JS_P2          3'h3
`define LWC_JS_P3          3'h7
`define LWC_JS_P4          3'h6
`define LWC_JS_LAST        3'h4

// phase at which a read samples the settled ram output
`define LWC_JS_SAMPLE      `LWC_JS_P2

// bit positions of the johnson word: feedback msb and the two strobe bits
`define LWC_JS_MSB         2
`define LWC_STB_HI         1
`define LWC_STB_LO         0

// reset values
`define LWC_ADDR_RST       5'h0
`define LWC_BIT_RST        1'h0
`define LWC_READY_RST      1'h1
// level used to raise a one-bit flag
`define LWC_BIT_SET        1'h1

`endif

// ===== hdl/lwc_pkg.sv
// types shared by the lut ram write controller
`default_nettype none
package lwc_pkg;

  // controller states
  typedef enum logic [1:0]
  {
    LWC_IDLE  = 2'b00, // waiting for a command
    LWC_READ  = 2'b01, // address steady, waiting to sample
    LWC_WRITE = 2'b10  // johnson-sequenced strobe pulse
  } lwc_state_type;

  // johnson phase word
  typedef logic [2:0] lwc_phase_type;

endpackage
`default_nettype wire

// ===== hdl/lwc_seq_if.sv
// carrier between the controller and its johnson sequencer
`default_nettype none
interface lwc_seq_if;

  logic                  run;   // advance while high, rest when low
  lwc_pkg::lwc_phase_type phase; // current johnson phase

  // controller side
  modport ctrl
  (
    output run,
    input  phase
  );

  // sequencer side
  modport seq
  (
    input  run,
    output phase
  );

endinterface
`default_nettype wire

// ===== hdl/lwc_johnson_seq.sv
// three-bit johnson phase counter, one bit changes per step
`include "lwc_regs.svh"
`default_nettype none
module lwc_johnson_seq
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link to the controller
  lwc_seq_if.seq   seqIf
);

  lwc_pkg::lwc_phase_type phase_r;   // registered phase
  lwc_pkg::lwc_phase_type phase_nxt; // next phase

  // shift the inverted msb in; one bit per step keeps decodes hazard free
  always_comb
  begin
    if (seqIf.run)
    begin
      phase_nxt = {phase_r[`LWC_JS_MSB-1:0], ~phase_r[`LWC_JS_MSB]};
    end
    else
    begin
      phase_nxt = `LWC_JS_REST; // idle rests at the all-zero phase
    end
  end

  // register only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      phase_r <= `LWC_JS_REST;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  assign seqIf.phase = phase_r;

endmodule
`default_nettype wire

// ===== tb/lwc_ram_ctrl_checker.sv
// concurrent checks on the pins of the lut ram write controller
`include "lwc_regs.svh"
`default_nettype none
module lwc_ram_ctrl_checker
(
  // clock and reset
  input wire logic                      clk,
  input wire logic                      sys_rst,
  // user side
  input wire logic                      cmdValid,
  input wire logic                      cmdWrite,
  input wire logic [`LWC_ADDR_BITS-1:0] cmdAddr,
  input wire logic                      cmdData,
  input wire logic                      cmdReady,
  input wire logic                      rspValid,
  input wire logic                      rspData,
  // ram side
  input wire logic [`LWC_ADDR_BITS-1:0] ramAddr,
  input wire logic                      ramDataIn,
  input wire logic                      ramWriteEn,
  input wire logic                      ramDataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a command is taken on this edge
  wire logic takeRd = cmdValid && cmdReady && !cmdWrite;
  wire logic takeWr = cmdValid && cmdReady && cmdWrite;

  AST_RD_NO_STROBE: assert property (takeRd |=> !ramWriteEn [*4])
    else $error("strobe rose during a read");
  AST_WR_STROBE: assert property (takeWr |-> ##4 ramWriteEn [*2] ##1 !ramWriteEn)
    else $error("write strobe not a clean two-cycle pulse");
  // address and data must not move while the strobe is high or just after
  AST_ADDR_STEADY: assert property ((ramWriteEn || $fell(ramWriteEn)) |->
    $stable(ramAddr) && $stable(ramDataIn)) else $error("address moved under strobe");
  AST_ADDR_LOAD: assert property (takeWr |=> ramAddr == $past(cmdAddr))
    else $error("address not loaded from command");
  AST_RD_LAT: assert property (takeRd |=> !rspValid [*3] ##1 rspValid)
    else $error("read answer late or early");
  AST_WR_LAT: assert property (takeWr |=> !rspValid [*6] ##1 rspValid)
    else $error("write answer late or early");
  AST_BUSY: assert property ((takeRd || takeWr) |=> !cmdReady)
    else $error("ready stayed high after take");
  AST_READY_BACK: assert property (rspValid |-> cmdReady)
    else $error("ready low with answer");
endmodule
bind lwc_ram_ctrl lwc_ram_ctrl_checker u_chk (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
  .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
  .rspValid(rspValid), .rspData(rspData), .ramAddr(ramAddr), .ramDataIn(ramDataIn),
  .ramWriteEn(ramWriteEn), .ramDataOut(ramDataOut));
`default_nettype wire

// ===== tb/lwc_ram_model.sv
// behavioural 32x1 lut ram primitive
`include "lwc_regs.svh"
`default_nettype none
module lwc_ram_model
(
  // ram pins
  input  wire logic [`LWC_ADDR_BITS-1:0] addr,
  input  wire logic                      dataIn,
  input  wire logic                      writeEn,
  output var  logic                      dataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mem [`LWC_DEPTH_LARGE]; // 32 words, the 16-word form uses the low half
  initial foreach (mem[i]) mem[i] = 1'b0;
  // level-sensitive store, so a glitch would corrupt just as in silicon
  always @* if (writeEn) mem[addr] = dataIn;
  // no select pin: always driven, old word then new data
  always_comb dataOut = mem[addr];
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the lut ram write controller
`include "lwc_regs.svh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %0d want %0d", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // design pins
  logic                      clk      = 1'b0;
  logic                      sys_rst  = 1'b1;
  logic                      cmdValid = 1'b0;
  logic                      cmdWrite = 1'b0;
  logic                      cmdData  = 1'b0;
  logic [`LWC_ADDR_BITS-1:0] cmdAddr  = 5'h0;
  logic                      cmdReady, rspValid, rspData, ramDataIn, ramWriteEn, ramDataOut;
  logic [`LWC_ADDR_BITS-1:0] ramAddr;
  int                        bad_count = 0;
  int                        checked   = 0;

  lwc_ram_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspData(rspData), .ramAddr(ramAddr), .ramDataIn(ramDataIn), .ramWriteEn(ramWriteEn),
    .ramDataOut(ramDataOut));
  lwc_ram_model u_ram (.addr(ramAddr), .dataIn(ramDataIn), .writeEn(ramWriteEn),
    .dataOut(ramDataOut));

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  // one command; entered just after an edge with ready high; poke sends a refused command
  task automatic xfer(input logic wr, input logic [4:0] a, input logic d, input logic want,
                      input int lat, input logic poke);
    int n;
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr  = a;
    cmdData  = d;
    @(posedge clk);
    #1;
    n = 0;
    if (poke)
    begin
      cmdAddr = 5'h14;
      cmdData = 1'b1;
      @(posedge clk);
      #1;
      n = 1;
    end
    cmdValid = 1'b0;
    // bounded wait, the answer comes at a fixed cycle
    while (rspValid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, lat)
    `CHK(rspData, want)
  endtask

  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // idle pins straight after reset
  task automatic t_reset();
    `CHK(cmdReady, 1'b1)
    `CHK(ramWriteEn, 1'b0)
    $display("test reset done");
  endtask

  // boundary words written back to back, then read back
  task automatic t_wr_rd();
    logic [4:0] adr [4] = '{5'h00, 5'h1F, 5'h0F, 5'h10};
    foreach (adr[i]) xfer(1'b1, adr[i], ~i[0], ~i[0], 6, 1'b0);
    foreach (adr[i]) xfer(1'b0, adr[i], 1'b0, ~i[0], 3, 1'b0);
    xfer(1'b1, 5'h00, 1'b0, 1'b0, 6, 1'b0);
    xfer(1'b0, 5'h1F, 1'b0, 1'b0, 3, 1'b0);
    $display("test wr_rd done");
  endtask

  // a command offered while busy leaves word 20 untouched
  task automatic t_refuse();
    xfer(1'b1, 5'h03, 1'b1, 1'b1, 6, 1'b1);
    xfer(1'b0, 5'h14, 1'b0, 1'b0, 3, 1'b0);
    $display("test refuse done");
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_wr_rd();
    t_refuse();
    complete_run();
  end

  // watchdog, far above the 78 cycles needed
  initial
  begin
    #100us;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
